/* File: rtl/acs_pkg.sv */
// ==========================================================
// shared constants of the converter channel sequencer
package acs_pkg;
  // word and field geometry
  localparam int WORD_W = 16; // one serial frame word
  localparam int DATA_W = 12; // converter result width
  localparam int NCH = 8; // analog channels
  localparam int NSEL = 9; // channels plus the die temperature slot
  localparam int IDX_W = 4; // width of a slot index
  localparam int CMD_BIT = 15; // 0 marks a configuration word
  localparam int ADDR_HI = 14; // register address field
  localparam int ADDR_LO = 11;
  localparam int REP_BIT = 9; // sequence_repeat_flag
  localparam int TEMP_BIT = 8; // temperature slot enable
  localparam int BUSY_EN_BIT = 8; // busy enable in output configuration
  localparam int IO7_BIT = 7; // pin_seven output select
  localparam int CH_HI = 7; // channel_select_bits
  localparam int RES_CH_HI = 14; // channel address in a result word
  localparam int RES_CH_LO = 12;
  localparam int SEQ_W = 10; // stored part of conversion_sequence_select
  // register addresses carried in the word
  localparam logic [3:0] ADDR_SEQ = 4'h2; // conversion_sequence_select
  localparam logic [3:0] ADDR_PIN = 4'h4; // analog_input_pin_select
  localparam logic [3:0] ADDR_OUTCFG = 4'h8; // output configuration
  // reset values
  localparam logic [SEQ_W-1:0] SEQ_RST = 10'h000;
  localparam logic [NCH-1:0] PIN_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [IDX_W-1:0] IDX_RST = 4'h0;
  localparam logic [IDX_W-1:0] TEMP_IDX = 4'h8; // slot of the temperature reading
  localparam logic [4:0] BIT_CNT_LAST = 5'h0f; // index of the 16th bit
  localparam logic [4:0] BIT_CNT_RST = 5'h00;
  // conversion timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 1000; // time a conversion takes
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_CNT_LOAD = 8'(CONV_CYCLES);
  localparam logic [7:0] CONV_CNT_ONE = 8'h01;
  localparam logic [7:0] CONV_CNT_RST = 8'h00;
  // converter state
  typedef enum logic {CV_IDLE, CV_RUN} acs_conv_t;
endpackage : acs_pkg

/* File: rtl/acs_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// two-flop synchroniser, one bit per lane
module acs_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q; // first stage, read only by the second

  // both stages reset to the idle level of the lane
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : acs_sync2
`default_nettype wire

/* File: rtl/acs_chan_pick.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// finds the lowest selected slot and the next one above cur
module acs_chan_pick (
  input wire logic [acs_pkg::NSEL-1:0] mask_in,
  input wire logic [acs_pkg::IDX_W-1:0] cur_in,
  output logic [acs_pkg::IDX_W-1:0] first_out,
  output logic [acs_pkg::IDX_W-1:0] next_out,
  output logic has_next_out
);
  // scan downwards so the lowest match is the one that sticks
  always_comb begin
    first_out = acs_pkg::IDX_RST;
    next_out = acs_pkg::IDX_RST;
    has_next_out = 1'b0;
    for (int i = acs_pkg::NSEL - 1; i >= 0; i--) begin
      if (mask_in[i]) begin
        first_out = i[acs_pkg::IDX_W-1:0];
      end
      if (mask_in[i] && (i > int'(cur_in))) begin
        next_out = i[acs_pkg::IDX_W-1:0];
        has_next_out = 1'b1;
      end
    end
  end
endmodule : acs_chan_pick
`default_nettype wire

/* File: rtl/acs_sequencer.sv */
// What this block does
// (R01) pin register write selects analog input pins
// (R02) sequence register write selects converted channels
// (R03) bit nine set makes sequence repeat
// (R04) bit eight adds temperature slot to sequence
// (R05) output bits of sequence write frame invalid
// (R06) host waits 500 ns before first trigger
// (R07) next frame falling edge starts first conversion
// (R08) later edges shift previous result, start next
// (R09) selected channels converted in ascending order
// (R10) after last: repeat, or stop and three-state
// (R11) busy pin low converting, high when ready
// (R12) result: bit15 zero, address, twelve data bits
// (R13) channel address binary, zero to seven
// (R14) all-zero sequence write ends the sequence
// (R15) host waits 2 us before new sequence
// (R16) host waits 500 ns after new sequence
// (R17) host writes reserved bits as zero
// (R18) reset clears flags and pin selections
// (R19) busy needs busy enable and output bit
// (R20) host avoids readback during a sequence
// (R21) one msb-first 16-bit word per frame
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer (
  input wire logic CLK_IN, // 100 MHz system clock
  input wire logic RSTN_IN, // asynchronous reset, active low
  input wire logic SERIAL_CLK_IN, // link clock from the host
  input wire logic FRAME_SEL_N_IN, // frame select, low during a frame
  input wire logic SERIAL_IN_PIN_IN, // serial data from the host
  output logic SERIAL_OUT_PIN_OUT, // serial data to the host
  output logic SERIAL_OUT_PIN_OE_OUT, // high while the output is driven
  output logic PIN_SEVEN_OUT, // busy level on pin seven
  output logic PIN_SEVEN_OE_OUT, // high while pin seven is driven
  output logic [acs_pkg::NCH-1:0] ANALOG_PIN_SEL_OUT, // pins set as analog inputs
  output logic CONV_START_OUT, // one-cycle start to the converter
  output logic [acs_pkg::IDX_W-1:0] CONV_CHAN_OUT, // slot to convert, 8 is temperature
  input wire logic [acs_pkg::DATA_W-1:0] CONV_DATA_IN // converter result at end of conversion
);
  // ==========================================================
  // reset release
  logic rst_meta_q; // first reset stage
  logic rst_n_q; // released reset used everywhere

  // release through two flops so no flop sees a ragged release
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // link domain: receive shift on rising serial clock edges
  logic link_clr; // frame end or reset clears the bit counter
  logic [4:0] bit_cnt_q; // bits received in this frame
  logic [acs_pkg::WORD_W-1:0] rx_sr_q; // receive shift register
  logic [acs_pkg::WORD_W-1:0] rx_word_q; // last complete word, held for the crossing
  logic rx_tgl_q; // flips once per complete word
  logic edge_tgl_q; // flips once per rising serial clock edge, for the first 16 of a frame

  // the link clock stops between frames, so the frame's own level ends it
  assign link_clr = FRAME_SEL_N_IN | ~rst_n_q;

  // bit counter and shift register live only for one frame
  always_ff @(posedge SERIAL_CLK_IN or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_q <= acs_pkg::BIT_CNT_RST;
      rx_sr_q <= acs_pkg::WORD_RST;
    end else begin
      rx_sr_q <= {rx_sr_q[acs_pkg::WORD_W-2:0], SERIAL_IN_PIN_IN}; // R21
      if (bit_cnt_q <= acs_pkg::BIT_CNT_LAST) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // word handover and edge events survive the frame end
  always_ff @(posedge SERIAL_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_word_q <= acs_pkg::WORD_RST;
      rx_tgl_q <= 1'b0;
      edge_tgl_q <= 1'b0;
    end else if (!FRAME_SEL_N_IN && (bit_cnt_q <= acs_pkg::BIT_CNT_LAST)) begin
      edge_tgl_q <= ~edge_tgl_q;
      if (bit_cnt_q == acs_pkg::BIT_CNT_LAST) begin
        // word stays still for 16 more edges, long enough to be read
        rx_word_q <= {rx_sr_q[acs_pkg::WORD_W-2:0], SERIAL_IN_PIN_IN}; // R21
        rx_tgl_q <= ~rx_tgl_q;
      end
    end
  end

  // ==========================================================
  // crossing into the system clock
  logic frame_n_s; // synchronised frame select
  logic rx_tgl_s; // synchronised word toggle
  logic edge_tgl_s; // synchronised edge toggle
  logic frame_n_d_q; // previous frame select level
  logic rx_seen_q; // last word toggle acted upon
  logic edge_seen_q; // last edge toggle acted upon
  logic frame_fall; // frame just started
  logic rx_evt; // a new word is ready
  logic edge_evt; // the host just took a bit

  acs_sync2 #(
    .W(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n_q),
    .d_in({FRAME_SEL_N_IN, rx_tgl_q, edge_tgl_q}),
    .q_out({frame_n_s, rx_tgl_s, edge_tgl_s})
  );

  // event detection on the synchronised levels
  always_ff @(posedge CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      frame_n_d_q <= 1'b1;
      rx_seen_q <= 1'b0;
      edge_seen_q <= 1'b0;
    end else begin
      frame_n_d_q <= frame_n_s;
      rx_seen_q <= rx_tgl_s;
      edge_seen_q <= edge_tgl_s;
    end
  end

  assign frame_fall = frame_n_d_q & ~frame_n_s;
  assign rx_evt = rx_tgl_s ^ rx_seen_q;
  assign edge_evt = edge_tgl_s ^ edge_seen_q;

  // ==========================================================
  // configuration registers
  logic seq_wr; // word addresses the sequence register
  logic [acs_pkg::SEQ_W-1:0] seq_q; // repeat, temperature, channels
  logic [acs_pkg::NCH-1:0] pin_sel_q; // analog input pin selection
  logic busy_en_q; // pin seven acts as busy
  logic io7_out_q; // pin seven set as an output

  assign seq_wr = rx_evt && !rx_word_q[acs_pkg::CMD_BIT]
    && (rx_word_q[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO] == acs_pkg::ADDR_SEQ);

  // writes decode only configuration words; others are ignored here
  always_ff @(posedge CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seq_q <= acs_pkg::SEQ_RST; // R18
      pin_sel_q <= acs_pkg::PIN_RST; // R18
      busy_en_q <= 1'b0;
      io7_out_q <= 1'b0;
    end else if (rx_evt && !rx_word_q[acs_pkg::CMD_BIT]) begin
      unique case (rx_word_q[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO])
        acs_pkg::ADDR_SEQ: begin
          seq_q <= rx_word_q[acs_pkg::SEQ_W-1:0]; // R02
        end
        acs_pkg::ADDR_PIN: begin
          pin_sel_q <= rx_word_q[acs_pkg::CH_HI:0]; // R01
        end
        acs_pkg::ADDR_OUTCFG: begin
          busy_en_q <= rx_word_q[acs_pkg::BUSY_EN_BIT];
          io7_out_q <= rx_word_q[acs_pkg::IO7_BIT];
        end
        default: begin
          // other registers belong to other blocks
        end
      endcase
    end
  end

  // ==========================================================
  // sequence walker
  logic [acs_pkg::NSEL-1:0] slot_mask; // channels plus temperature slot
  logic [acs_pkg::NSEL-1:0] new_mask; // mask carried by a sequence write
  logic [acs_pkg::IDX_W-1:0] first_idx; // lowest slot of the live mask
  logic [acs_pkg::IDX_W-1:0] next_idx; // next slot above the current one
  logic [acs_pkg::IDX_W-1:0] new_first; // lowest slot of a written mask
  logic has_next; // a higher slot remains
  logic seq_active_q; // a sequence is running
  logic [acs_pkg::IDX_W-1:0] cur_q; // slot converted on the next trigger

  assign slot_mask = seq_q[acs_pkg::TEMP_BIT:0]; // R04
  assign new_mask = rx_word_q[acs_pkg::TEMP_BIT:0];

  acs_chan_pick u_pick (
    .mask_in(slot_mask),
    .cur_in(cur_q),
    .first_out(first_idx),
    .next_out(next_idx),
    .has_next_out(has_next)
  );

  acs_chan_pick u_pick_new (
    .mask_in(new_mask),
    .cur_in(acs_pkg::IDX_RST),
    .first_out(new_first),
    .next_out(),
    .has_next_out()
  );

  // a sequence write wins over a trigger in the same cycle
  always_ff @(posedge CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seq_active_q <= 1'b0;
      cur_q <= acs_pkg::IDX_RST;
    end else if (seq_wr) begin
      // the new sequence starts tracking its first slot
      seq_active_q <= |rx_word_q[acs_pkg::REP_BIT:0]; // R14
      cur_q <= new_first;
    end else if (frame_fall && seq_active_q) begin
      if (has_next) begin
        cur_q <= next_idx; // R09
      end else if (seq_q[acs_pkg::REP_BIT] && (|slot_mask)) begin
        cur_q <= first_idx; // R03 R10
      end else begin
        seq_active_q <= 1'b0; // R10
      end
    end
  end

  // ==========================================================
  // conversion timer standing in for the converter core
  acs_pkg::acs_conv_t conv_st_q; // converter state
  logic [7:0] conv_cnt_q; // cycles left in a conversion
  logic conv_done; // conversion ends this cycle
  logic [acs_pkg::WORD_W-1:0] result_q; // last finished result word
  logic pending_q; // result waits for the next frame
  logic [2:0] res_addr; // channel address for the result word

  assign conv_done = (conv_st_q == acs_pkg::CV_RUN) && (conv_cnt_q == acs_pkg::CONV_CNT_ONE);
  assign res_addr = (CONV_CHAN_OUT == acs_pkg::TEMP_IDX) ? 3'h0 : CONV_CHAN_OUT[2:0]; // R13

  // a trigger during a running conversion is ignored
  always_ff @(posedge CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      conv_st_q <= acs_pkg::CV_IDLE;
      conv_cnt_q <= acs_pkg::CONV_CNT_RST;
      CONV_START_OUT <= 1'b0;
      CONV_CHAN_OUT <= acs_pkg::IDX_RST;
    end else begin
      CONV_START_OUT <= 1'b0;
      unique case (conv_st_q)
        acs_pkg::CV_IDLE: begin
          if (frame_fall && seq_active_q && !seq_wr) begin
            conv_st_q <= acs_pkg::CV_RUN; // R07 R08
            conv_cnt_q <= acs_pkg::CONV_CNT_LOAD;
            CONV_START_OUT <= 1'b1;
            CONV_CHAN_OUT <= cur_q;
          end
        end
        acs_pkg::CV_RUN: begin
          conv_cnt_q <= conv_cnt_q - acs_pkg::CONV_CNT_ONE;
          if (conv_done) begin
            conv_st_q <= acs_pkg::CV_IDLE;
          end
        end
      endcase
    end
  end

  // result word capture; a new result wins over the frame that empties it
  always_ff @(posedge CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      result_q <= acs_pkg::WORD_RST;
      pending_q <= 1'b0;
    end else if (conv_done) begin
      result_q <= {1'b0, res_addr, CONV_DATA_IN}; // R12
      pending_q <= 1'b1;
    end else if (frame_fall) begin
      pending_q <= 1'b0; // R08
    end
  end

  // ==========================================================
  // transmit side, stepped by synchronised link clock edges
  logic [acs_pkg::WORD_W-1:0] tx_sr_q; // bits still to send

  // the host samples on rising edges; each bit moves on after one
  always_ff @(posedge CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_sr_q <= acs_pkg::WORD_RST;
      SERIAL_OUT_PIN_OUT <= 1'b0;
      SERIAL_OUT_PIN_OE_OUT <= 1'b0;
    end else if (frame_fall) begin
      // no result pending (sequence write, stopped sequence) leaves the line free
      tx_sr_q <= pending_q ? result_q : acs_pkg::WORD_RST; // R05 R08
      SERIAL_OUT_PIN_OUT <= pending_q & result_q[acs_pkg::WORD_W-1];
      SERIAL_OUT_PIN_OE_OUT <= pending_q; // R10
    end else if (frame_n_s) begin
      SERIAL_OUT_PIN_OE_OUT <= 1'b0;
    end else if (edge_evt) begin
      tx_sr_q <= {tx_sr_q[acs_pkg::WORD_W-2:0], 1'b0}; // R21
      SERIAL_OUT_PIN_OUT <= tx_sr_q[acs_pkg::WORD_W-2];
    end
  end

  // ==========================================================
  // pins: analog selection and busy on pin seven
  always_ff @(posedge CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ANALOG_PIN_SEL_OUT <= acs_pkg::PIN_RST;
      PIN_SEVEN_OUT <= 1'b1;
      PIN_SEVEN_OE_OUT <= 1'b0;
    end else begin
      ANALOG_PIN_SEL_OUT <= pin_sel_q; // R01
      PIN_SEVEN_OUT <= (conv_st_q != acs_pkg::CV_RUN); // R11
      PIN_SEVEN_OE_OUT <= busy_en_q & io7_out_q; // R19
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n_q);

  sequence s_conv_begin;
    CONV_START_OUT && PIN_SEVEN_OE_OUT;
  endsequence

  sequence s_busy_low;
    !PIN_SEVEN_OUT;
  endsequence

  seq_load_a: assert property (seq_wr |=> seq_q == $past(rx_word_q[acs_pkg::SEQ_W-1:0])) // R02
    else $error("sequence register not loaded");
  pin_load_a: assert property (rx_evt && !rx_word_q[acs_pkg::CMD_BIT]
    && rx_word_q[acs_pkg::ADDR_HI:acs_pkg::ADDR_LO] == acs_pkg::ADDR_PIN
    |=> ##1 ANALOG_PIN_SEL_OUT == $past(rx_word_q[acs_pkg::CH_HI:0], 2)) // R01
    else $error("pin selection not applied");
  result_fmt_a: assert property (conv_done |=> !result_q[acs_pkg::WORD_W-1]
    && result_q[acs_pkg::RES_CH_HI:acs_pkg::RES_CH_LO] == $past(res_addr)) // R12
    else $error("result word malformed");
  conv_start_a: assert property (frame_fall && seq_active_q && !seq_wr && conv_st_q == acs_pkg::CV_IDLE
    |=> CONV_START_OUT && CONV_CHAN_OUT == $past(cur_q)) // R07
    else $error("trigger did not start conversion");
  asc_order_a: assert property (frame_fall && seq_active_q && has_next && !seq_wr
    |=> cur_q > $past(cur_q)) // R09
    else $error("sequence not ascending");
  seq_stop_a: assert property (seq_wr && !(|rx_word_q[acs_pkg::REP_BIT:0]) |=> !seq_active_q) // R14
    else $error("stop write did not end sequence");
  last_stop_a: assert property (frame_fall && seq_active_q && !has_next && !seq_q[acs_pkg::REP_BIT]
    && !seq_wr |=> !seq_active_q) // R10
    else $error("sequence did not stop after last slot");
  out_release_a: assert property (frame_fall && !pending_q && !conv_done |=> !SERIAL_OUT_PIN_OE_OUT) // R10
    else $error("output driven without result");
  result_out_a: assert property (frame_fall && pending_q
    |=> SERIAL_OUT_PIN_OE_OUT && SERIAL_OUT_PIN_OUT == $past(result_q[acs_pkg::WORD_W-1])) // R08
    else $error("pending result not sent");
  busy_low_a: assert property (s_conv_begin |=> s_busy_low ##[1:120] PIN_SEVEN_OUT) // R11
    else $error("busy pin did not follow conversion");
  reset_clear_a: assert property ($rose(rst_n_q) |-> seq_q == acs_pkg::SEQ_RST
    && pin_sel_q == acs_pkg::PIN_RST) // R18
    else $error("registers not cleared by reset");
endmodule : acs_sequencer
`default_nettype wire

/* File: dv/acs_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// serial host: one word per frame, link clock idles low between frames
module acs_host_model (
  output logic sclk_out, // 125 ns period, only inside frames
  output logic frame_n_out, // low for the length of a frame
  output logic sdi_out, // word to the device, msb first
  input wire logic sdo_in, // device serial output
  input wire logic sdo_oe_in, // device output enable
  output logic oe_seen_out // enable seen at any rising edge of the last frame
);
  logic last_b; // last bit read; a floating line reads as its inverse
  initial begin
    sclk_out = 1'b0;
    frame_n_out = 1'b1;
    sdi_out = 1'b0;
    oe_seen_out = 1'b0;
    last_b = 1'b0;
  end
  // one frame; this host never asks for readback of anything
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    oe_seen_out = 1'b0;
    frame_n_out = 1'b0;
    #10;
    // 16 bits each way, msb first; sdi changes while the clock is low
    for (int k = 15; k >= 0; k--) begin
      sdi_out = w[k];
      #62;
      sclk_out = 1'b1;
      last_b = sdo_oe_in ? sdo_in : ~last_b;
      r[k] = last_b;
      oe_seen_out = oe_seen_out | sdo_oe_in;
      #63;
      sclk_out = 1'b0;
    end
    #40;
    frame_n_out = 1'b1;
    // released data line does not keep its last value
    sdi_out = ~sdi_out;
    #100;
  endtask : xfer
endmodule : acs_host_model
`default_nettype wire

/* File: dv/adc_channel_sequencer_spi_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ==========================================================
// bench top
module adc_channel_sequencer_spi_bench;
  logic clk, rst_n, sclk, frame_n, serial_in_pin, serial_out_pin, sdo_oe, busy, busy_oe, conv_start, oe_seen;
  logic [7:0] pin_sel; // analog pin selection seen at the port
  logic [3:0] conv_chan; // slot being converted
  logic [11:0] conv_data; // converter result fed back
  int err_total, samples_checked;
  int conv_age = 200; // cycles since the last start, saturating
  logic [3:0] exp_slot[$]; // slots expected to start, in order
  logic [15:0] res_q[$]; // result words expected, in start order
  logic [3:0] e_slot;
  logic [11:0] d_next;
  logic [7:0] p;

  acs_sequencer i_acs_sequencer (
    .CLK_IN(clk), .RSTN_IN(rst_n), .SERIAL_CLK_IN(sclk), .FRAME_SEL_N_IN(frame_n),
    .SERIAL_IN_PIN_IN(serial_in_pin), .SERIAL_OUT_PIN_OUT(serial_out_pin), .SERIAL_OUT_PIN_OE_OUT(sdo_oe),
    .PIN_SEVEN_OUT(busy), .PIN_SEVEN_OE_OUT(busy_oe), .ANALOG_PIN_SEL_OUT(pin_sel),
    .CONV_START_OUT(conv_start), .CONV_CHAN_OUT(conv_chan), .CONV_DATA_IN(conv_data)
  );
  acs_host_model i_acs_host_model (
    .sclk_out(sclk), .frame_n_out(frame_n), .sdi_out(serial_in_pin), .sdo_in(serial_out_pin),
    .sdo_oe_in(sdo_oe), .oe_seen_out(oe_seen)
  );

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // expected result word; temperature slot reports address zero
  function automatic logic [15:0] res_word(input logic [3:0] slot, input logic [11:0] d);
    return {1'b0, (slot == acs_pkg::TEMP_IDX) ? 3'b000 : slot[2:0], d};
  endfunction : res_word

  // ==========================================================
  // converter stand-in: checks slot order, supplies random data, times busy
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      e_slot = (exp_slot.size() > 0) ? exp_slot.pop_front() : 4'hx;
      `CHK(conv_chan, e_slot)
      d_next = 12'($urandom);
      conv_data <= d_next;
      res_q.push_back(res_word(conv_chan, d_next));
      conv_age <= 0;
    end else if (conv_age < 200) begin
      conv_age <= conv_age + 1;
    end
    if (conv_age == 5) `CHK(busy, 1'b0)
    if (conv_age == 110) `CHK(busy, 1'b1)
  end

  // one frame, then time for the word to be decoded
  task automatic write(input logic [15:0] w);
    logic [15:0] r;
    i_acs_host_model.xfer(w, r);
    repeat (10) @(posedge clk);
  endtask : write

  // runs a sequence; with repeat set it ends with the stop word
  task automatic run_seq(input logic [9:0] seq, input int frames);
    logic [15:0] r, w;
    logic [3:0] sl[$];
    int k, n;
    for (int s = 0; s < 9; s++) if (seq[s]) sl.push_back(4'(s));
    k = seq[9] ? frames : sl.size();
    // a repeating run also converts at the fall of the stop frame
    n = seq[9] ? frames + 1 : sl.size();
    for (int i = 0; i < n; i++) exp_slot.push_back(sl[i % sl.size()]);
    res_q.delete();
    // output of this frame carries nothing and is dropped; reserved bits zero
    i_acs_host_model.xfer({1'b0, 4'h2, 1'b0, seq}, r);
    `CHK(oe_seen, 1'b0)
    #600; // tracking time before the first trigger
    for (int i = 0; i <= k; i++) begin
      w = (i == k && seq[9]) ? 16'h1000 : 16'h0000;
      i_acs_host_model.xfer(w, r);
      if (i > 0) `CHK(r, res_q.pop_front())
      if (i > 0) `CHK(oe_seen, 1'b1)
    end
    #2000; // let the last conversion finish
    i_acs_host_model.xfer(16'h0000, r);
    if (!seq[9]) `CHK(oe_seen, 1'b0)
    if (seq[9]) `CHK(r, res_q.pop_front())
    `CHK(exp_slot.size(), 0)
  endtask : run_seq

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    conv_data = 12'h000;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(53140));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(pin_sel, 8'h00)
    `CHK(busy_oe, 1'b0)
    `CHK(sdo_oe, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      p = (i == 0) ? 8'hff : 8'($urandom);
      write({1'b0, 4'h4, 3'b000, p});
      `CHK(pin_sel, p)
    end
    // a word with the top bit set is not a configuration word
    write({1'b1, 4'h4, 3'b000, 8'h00});
    `CHK(pin_sel, p)
    $display("test pin select done");
    write(16'h4100);
    `CHK(busy_oe, 1'b0)
    write(16'h4180);
    `CHK(busy_oe, 1'b1)
    $display("test busy enable done");
    run_seq({1'b0, 1'b1, 8'($urandom)}, 0);
    $display("test single pass done");
    run_seq(10'h281, 5);
    $display("test repeat and stop done");
    report_and_stop();
  end

  // hang guard, far beyond the roughly 60 us the tests need
  initial begin
    #300000;
    err_total++;
    report_and_stop();
  end
endmodule : adc_channel_sequencer_spi_bench
`default_nettype wire
